// *** rtl/tlsprx_defs.svh ***
// Purpose : Constants for the three-lane serial-to-parallel receiver.
// Assumes : Included by the package and by the design modules.
// Notes   : Timing figures are kept in their own units beside cycle counts.
`ifndef TLSPRX_DEFS_SVH
`define TLSPRX_DEFS_SVH

`define TLSPRX_LANES        3
`define TLSPRX_BITS_LANE    7
`define TLSPRX_WORD_W       21
`define TLSPRX_SLOT_W       3
`define TLSPRX_SLOT_LAST    3'h6
`define TLSPRX_SLOT_FIRST   3'h0
`define TLSPRX_SLOT_SYNC    3'h3
`define TLSPRX_WORD_ONES    21'h1fffff
`define TLSPRX_WORD_ZERO    21'h000000
`define TLSPRX_CLK_MHZ      200
`define TLSPRX_LOCK_MS      10
`define TLSPRX_LOCK_CYC     (`TLSPRX_LOCK_MS * `TLSPRX_CLK_MHZ * 1000)
`define TLSPRX_LOSS_CYC     24'h000040
`define TLSPRX_CNT_W        24
`define TLSPRX_IDLE_CYC     24'h000010

`endif

// *** rtl/tlsprx_receiver.sv ***
// Purpose : Receive side of a source-clocked three-lane serial link.
// Assumes : LINK_BIT_CLK runs at seven times the forwarded word clock and
//           is phase aligned so that each rising edge is one bit slot.
// Notes   : Lane and clock pins are single-ended views of the differential
//           receivers; an idle pin (fail-safe) reads high.
// Functional notes
// [R1] Three lanes become one 21-bit word.
// [R2] Seven bits per lane per link clock.
// [R3] Link clock range 15 to 75 MHz.
// [R4] Strobe clock 50 percent duty, same frequency; the strobe copies the link clock's duty instead.
// [R5] Strobe rising edge marks valid word.
// [R6] Power-down low forces outputs low.
// [R7] Idle lanes with clock give all ones.
// [R8] Idle clock holds last valid word.
// [R9] Idle clock holds strobe low.
// [R10] Sample each lane at slots 0 to 6.
// [R11] Lock within 10 ms; data untrusted before.
// [R12] Lane k slot j maps to bit 7k+j.
`include "tlsprx_defs.svh"

package tlsprx_pkg;
    typedef logic [`TLSPRX_WORD_W-1:0] tlsprx_word_t;
    typedef enum logic [1:0] {TLSPRX_UNLOCKED, TLSPRX_LOCKED}
        tlsprx_lock_e;
endpackage : tlsprx_pkg

module tlsprx_receiver
    import tlsprx_pkg::*;
#(
    parameter int unsigned LOCK_CYC = `TLSPRX_LOCK_CYC
)
(
    input  wire logic                        CLK,
    input  wire logic                        RST,
    input  wire logic                        LINK_BIT_CLK,
    input  wire logic                        LINK_CLOCK_IN,
    input  wire logic [`TLSPRX_LANES-1:0]    SERIAL_LANE_IN,
    input  wire logic                        POWER_DOWN_N,
    output logic      [`TLSPRX_WORD_W-1:0]   PARALLEL_WORD_OUT,
    output logic                             WORD_STROBE_CLOCK_OUT,
    output logic                             LOCKED
);
    // ------------------------------------------------------------------
    // Link domain: bit slot counter and shift registers
    // ------------------------------------------------------------------
    logic [`TLSPRX_SLOT_W-1:0]   slot;
    logic [1:0]                  wclk_sync;
    logic                        wclk_prev;
    logic [`TLSPRX_WORD_W-1:0]   shift;
    tlsprx_word_t                link_word;
    logic                        link_toggle;
    logic [`TLSPRX_LANES-1:0]    lane_idle;
    logic [1:0]                  rst_link_sync;
    logic                        rst_link;
    logic                        wclk_rise;
    logic                        word_seen;
    tlsprx_word_t                assembled;

    // Reset is released into the link domain synchronously.
    always_ff @(posedge LINK_BIT_CLK or posedge RST)
    begin
        if (RST)
            rst_link_sync <= 2'h3;
        else
            rst_link_sync <= {rst_link_sync[0], 1'b0};
    end
    assign rst_link = rst_link_sync[1];

    // The forwarded word clock is sampled on the bit clock to find slot 0.
    always_ff @(posedge LINK_BIT_CLK or posedge rst_link)
    begin
        if (rst_link)
        begin
            wclk_sync <= 2'h0;
            wclk_prev <= 1'b0;
        end
        else
        begin
            wclk_sync <= {wclk_sync[0], LINK_CLOCK_IN};
            wclk_prev <= wclk_sync[1];
        end
    end

    assign wclk_rise = wclk_sync[1] && !wclk_prev;

    // The rise is seen two bit edges late, so the edge that sees it is
    // already sampling slot 2 and the next one samples slot 3.
    always_ff @(posedge LINK_BIT_CLK or posedge rst_link)
    begin
        if (rst_link)
            slot <= `TLSPRX_SLOT_FIRST;
        else if (wclk_rise)
            slot <= `TLSPRX_SLOT_SYNC;                         // see [R10]
        else if (slot == `TLSPRX_SLOT_LAST)
            slot <= `TLSPRX_SLOT_FIRST;
        else
            slot <= slot + 3'h1;                               // see [R2]
    end

    // Lane k slot j lands at bit 7k+j of the word.
    genvar k;
    generate
        for (k = 0; k < `TLSPRX_LANES; k++)
        begin : g_lane
            always_ff @(posedge LINK_BIT_CLK or posedge rst_link)
            begin
                if (rst_link)
                begin
                    shift[k*`TLSPRX_BITS_LANE +: `TLSPRX_BITS_LANE] <= '0;
                end
                else
                begin
                    shift[k*`TLSPRX_BITS_LANE + slot] <=
                        SERIAL_LANE_IN[k];                     // see [R12]
                end
            end
            // The last slot is taken straight from the pin, since the
            // word is latched on the very edge that samples it.
            assign assembled[k*`TLSPRX_BITS_LANE +: `TLSPRX_BITS_LANE-1] =
                shift[k*`TLSPRX_BITS_LANE +: `TLSPRX_BITS_LANE-1];
            assign assembled[k*`TLSPRX_BITS_LANE + `TLSPRX_BITS_LANE-1] =
                SERIAL_LANE_IN[k];                             // see [R12]
        end
    endgenerate

    // A whole word of ones on all lanes is what fail-safe bias gives.
    always_comb
    begin
        for (int i = 0; i < `TLSPRX_LANES; i++)
            lane_idle[i] =
                &assembled[i*`TLSPRX_BITS_LANE +: `TLSPRX_BITS_LANE];
    end

    // Only a word framed by a real clock rise is passed on, so a stopped
    // clock leaves the last valid word in place.
    always_ff @(posedge LINK_BIT_CLK or posedge rst_link)
    begin
        if (rst_link)
            word_seen <= 1'b0;
        else if (wclk_rise)
            word_seen <= 1'b1;                                 // see [R8]
        else if (slot == `TLSPRX_SLOT_LAST)
            word_seen <= 1'b0;
    end

    always_ff @(posedge LINK_BIT_CLK or posedge rst_link)
    begin
        if (rst_link)
        begin
            link_word   <= `TLSPRX_WORD_ZERO;
            link_toggle <= 1'b0;
        end
        else if (slot == `TLSPRX_SLOT_LAST && word_seen)
        begin
            // Idle lanes naturally yield all ones; forced here for clarity.
            link_word   <= (&lane_idle) ? `TLSPRX_WORD_ONES          // see [R7]
                         : assembled;                          // see [R1]
            link_toggle <= ~link_toggle;
        end
    end

    // ------------------------------------------------------------------
    // Core domain: crossing, lock, loss detection and outputs
    // ------------------------------------------------------------------
    logic [2:0]                  tog_sync;
    logic [1:0]                  pd_sync;
    logic [1:0]                  lclk_sync;
    logic                        lclk_prev;
    logic                        word_ready;
    logic [`TLSPRX_CNT_W-1:0]    since_edge;
    logic                        clk_present;
    logic [31:0]                 lock_cnt;
    tlsprx_lock_e                lock_state;
    tlsprx_word_t                held_word;
    logic                        strobe;
    logic                        next_strobe;
    logic                        word_load;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            tog_sync  <= 3'h0;
            pd_sync   <= 2'h0;
            lclk_sync <= 2'h0;
            lclk_prev <= 1'b0;
        end
        else
        begin
            tog_sync  <= {tog_sync[1:0], link_toggle};
            pd_sync   <= {pd_sync[0], POWER_DOWN_N};
            lclk_sync <= {lclk_sync[0], LINK_CLOCK_IN};
            lclk_prev <= lclk_sync[1];
        end
    end
    assign word_ready = tog_sync[2] ^ tog_sync[1];

    // A link clock with no edge for a while counts as floating.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            since_edge <= `TLSPRX_LOSS_CYC;
        else if (lclk_sync[1] != lclk_prev)
            since_edge <= '0;
        else if (since_edge != `TLSPRX_LOSS_CYC)
            since_edge <= since_edge + 24'h000001;
    end
    assign clk_present = (since_edge != `TLSPRX_LOSS_CYC);

    // Lock counter restarts whenever the clock goes away.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            lock_cnt   <= '0;
            lock_state <= TLSPRX_UNLOCKED;
        end
        else if (!clk_present || !pd_sync[1])
        begin
            lock_cnt   <= '0;
            lock_state <= TLSPRX_UNLOCKED;
        end
        else
        begin
            unique case (lock_state)
                TLSPRX_UNLOCKED:
                begin
                    if (lock_cnt >= LOCK_CYC - 1)
                        lock_state <= TLSPRX_LOCKED;           // see [R11]
                    else
                        lock_cnt <= lock_cnt + 32'h1;
                end
                TLSPRX_LOCKED:
                    lock_state <= TLSPRX_LOCKED;
                default:
                    lock_state <= TLSPRX_UNLOCKED;
            endcase
        end
    end

    // Captured words are held when the clock stops, so the last survives.
    assign word_load = word_ready && clk_present;              // see [R8]

    tlsprx_word_reg u_word
    (
        .clk     (CLK),
        .rst     (RST),
        .wr_en   (word_load),                                 // see [R8]
        .wr_data (link_word),
        .rd_data (held_word)
    );

    // The strobe follows the synchronised link clock: same frequency and
    // duty, and data is updated well before its rising edge.
    assign next_strobe = lclk_sync[1] && clk_present;   // see [R4] see [R9]

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            strobe <= 1'b0;
        else
            strobe <= next_strobe;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            PARALLEL_WORD_OUT <= `TLSPRX_WORD_ZERO;
        else if (!pd_sync[1])
            PARALLEL_WORD_OUT <= `TLSPRX_WORD_ZERO;            // see [R6]
        // The word never moves on the edge that raises the strobe.
        else if (!strobe && !next_strobe)
            PARALLEL_WORD_OUT <= held_word;                    // see [R5]
    end

    assign WORD_STROBE_CLOCK_OUT = strobe && pd_sync[1];       // see [R6]
    // Link clock range (15 to 75 MHz) is the sender's duty; see [R3]
    assign LOCKED = (lock_state == TLSPRX_LOCKED);
endmodule : tlsprx_receiver

// *** rtl/tlsprx_word_reg.sv ***
// Purpose : Holding register for one recovered parallel word.
// Assumes : Single clock, asynchronous active-high reset.
// Notes   : Read data always come out of a flip-flop.
`include "tlsprx_defs.svh"

module tlsprx_word_reg
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       wr_en,
    input  wire logic [`TLSPRX_WORD_W-1:0]  wr_data,
    output logic      [`TLSPRX_WORD_W-1:0]  rd_data
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_data <= `TLSPRX_WORD_ZERO;
        else if (wr_en)
            rd_data <= wr_data;
    end
endmodule : tlsprx_word_reg

// *** testbench/tlsprx_receiver_asserts.sv ***
// Purpose: Port checks for the receiver.
// Assumes: Bound to the receiver from the bench top file.
// Notes  : Link silence is timed in core clock cycles.
// ----------------
// Checker
// ----------------
module tlsprx_receiver_asserts
    import tlsprx_pkg::*;
#(
    parameter int unsigned LOCK_CYC = 50
)
(
    input wire logic         CLK,
    input wire logic         RST,
    input wire logic         LINK_CLOCK_IN,
    input wire logic         POWER_DOWN_N,
    input wire tlsprx_word_t PARALLEL_WORD_OUT,
    input wire logic         WORD_STROBE_CLOCK_OUT,
    input wire logic         LOCKED
);
    logic        last_clk;
    logic [7:0]  idle;
    logic [15:0] act;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            last_clk <= 1'b0;
        else
            last_clk <= LINK_CLOCK_IN;
    always_ff @(posedge CLK or posedge RST)
        if (RST || LINK_CLOCK_IN != last_clk)
            idle <= 8'h00;
        else if (idle != 8'hff)
            idle <= idle + 8'h01;
    // Time with a live link clock, so the lock bound restarts on each loss.
    always_ff @(posedge CLK or posedge RST)
        if (RST || idle >= 8'h40 || !POWER_DOWN_N)
            act <= 16'h0000;
        else if (act != 16'hffff)
            act <= act + 16'h0001;
    a_pd_outputs_low:
        assert property (!POWER_DOWN_N [*4] |->
            PARALLEL_WORD_OUT == '0 && !WORD_STROBE_CLOCK_OUT)
        else $error("power-down outputs not low");
    a_edge_word_stable:
        assert property ($rose(WORD_STROBE_CLOCK_OUT) |->
            $stable(PARALLEL_WORD_OUT)) else $error("word moved at strobe");
    a_loss_strobe_low:
        assert property (idle > 8'h50 |-> !WORD_STROBE_CLOCK_OUT)
        else $error("strobe not low on clock loss");
    a_loss_word_hold:
        assert property (idle > 8'h50 && POWER_DOWN_N && $past(POWER_DOWN_N, 4)
            |-> $stable(PARALLEL_WORD_OUT)) else $error("word not held");
    a_lock_bound:
        assert property (act > LOCK_CYC + 100 |-> LOCKED)
        else $error("lock too late");
    a_strobe_follows:
        assert property (disable iff (RST || !POWER_DOWN_N)
            LOCKED && $rose(LINK_CLOCK_IN) |-> ##[1:6]
            $rose(WORD_STROBE_CLOCK_OUT)) else $error("strobe missing");
    a_high_time:
        assert property (disable iff (RST || !POWER_DOWN_N)
            $rose(WORD_STROBE_CLOCK_OUT) && $past(POWER_DOWN_N, 4) |=>
            WORD_STROBE_CLOCK_OUT [*8]) else $error("strobe high too short");
    a_low_time:
        assert property (disable iff (RST || !POWER_DOWN_N)
            $fell(WORD_STROBE_CLOCK_OUT) && $past(POWER_DOWN_N, 4) |=>
            !WORD_STROBE_CLOCK_OUT [*8]) else $error("strobe low too short");
endmodule : tlsprx_receiver_asserts

// *** testbench/tlsprx_receiver_bench.sv ***
// Purpose: Self-checking bench for the receiver.
// Assumes: Words are held for several link periods before a check.
// Notes  : Lock count is cut to 50 cycles.
// ----------------
// Bench
// ----------------
module tlsprx_receiver_bench
    import tlsprx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LOCK = 50;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         bit_clk = 1'b0;
    logic         pdn = 1'b1;
    logic         run = 1'b0;
    logic         lane_idle = 1'b0;
    tlsprx_word_t tx = '0;
    tlsprx_word_t rx;
    logic         link_clk;
    logic [2:0]   lanes;
    logic         strobe;
    logic         locked;
    int           n_errors = 0;
    int           comparisons = 0;
    tlsprx_receiver #(.LOCK_CYC(LOCK)) u_tlsprx_receiver (.CLK(clk),
        .RST(rst), .LINK_BIT_CLK(bit_clk), .LINK_CLOCK_IN(link_clk),
        .SERIAL_LANE_IN(lanes), .POWER_DOWN_N(pdn), .PARALLEL_WORD_OUT(rx),
        .WORD_STROBE_CLOCK_OUT(strobe), .LOCKED(locked));
    tlsprx_serializer_model u_tlsprx_serializer_model (.bit_clk(bit_clk),
        .run(run), .lanes_idle(lane_idle), .word(tx), .link_clk(link_clk),
        .lanes(lanes));
    initial forever #2.5 clk = ~clk;
    initial
    begin
        #7.3;
        forever #15 bit_clk = ~bit_clk;
    end
    function automatic tlsprx_word_t want(input tlsprx_word_t w, input logic i);
        return i ? 21'h1fffff : w;
    endfunction : want
    function automatic logic duty_ok(input int hi, input int lo);
        return hi + lo > 40 && hi + lo < 44 && hi - lo < 8 && lo - hi < 8;
    endfunction : duty_ok
    task automatic chk(input tlsprx_word_t seen, input tlsprx_word_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic strobes(input int n);
        repeat (n) @(posedge strobe);
        @(negedge clk);
    endtask : strobes
    task automatic relock;
        for (int i = 0; i < 2000 && locked !== 1'b1; i++)
            @(negedge clk);
        chk(21'(locked), 21'h1);
    endtask : relock
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial
    begin
        tlsprx_word_t w;
        int           hi;
        int           lo;
        void'($urandom(32'h8ecb));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        run = 1'b1;
        relock();
        for (int i = 0; i < 12; i++)
        begin
            w = (i == 0) ? 21'h00007f : (i == 1) ? 21'h100001 : 21'($urandom);
            tx = w;
            strobes(5);
            chk(rx, want(w, 1'b0));
        end
        strobes(1);
        hi = 0;
        lo = 0;
        while (strobe === 1'b1 && hi < 99)
        begin
            hi++;
            @(negedge clk);
        end
        while (strobe === 1'b0 && lo < 99)
        begin
            lo++;
            @(negedge clk);
        end
        chk(21'(duty_ok(hi, lo)), 21'h1);
        pdn = 1'b0;
        repeat (4) @(negedge clk);
        repeat (50)
        begin
            chk(rx | 21'(strobe), 21'h0);
            @(negedge clk);
        end
        pdn = 1'b1;
        strobes(5);
        chk(rx, want(w, 1'b0));
        lane_idle = 1'b1;
        strobes(5);
        chk(rx, want(w, 1'b1));
        run = 1'b0;
        repeat (150) @(negedge clk);
        chk(21'(strobe), 21'h0);
        chk(rx, want(w, 1'b1));
        lane_idle = 1'b0;
        run = 1'b1;
        relock();
        strobes(5);
        chk(rx, want(w, 1'b0));
        conclude();
    end
endmodule : tlsprx_receiver_bench
bind tlsprx_receiver tlsprx_receiver_asserts #(.LOCK_CYC(LOCK_CYC)) u_asserts
    (.CLK, .RST, .LINK_CLOCK_IN, .POWER_DOWN_N, .PARALLEL_WORD_OUT,
    .WORD_STROBE_CLOCK_OUT, .LOCKED);

// *** testbench/tlsprx_serializer_model.sv ***
// Purpose: Serializer driving three lanes and the word clock.
// Assumes: Bit clock comes from the bench.
// Notes  : An idle pin reads high, as the fail-safe bias makes it.
// ----------------
// Serializer
// ----------------
module tlsprx_serializer_model
    import tlsprx_pkg::*;
(
    input  wire logic         bit_clk,
    input  wire logic         run,
    input  wire logic         lanes_idle,
    input  wire tlsprx_word_t word,
    output logic              link_clk,
    output logic [2:0]        lanes
);
    logic [2:0]   slot = 3'h6;
    logic         stopped = 1'b1;
    tlsprx_word_t cur = '0;
    // Stopping only at a word boundary keeps the last word whole.
    always @(negedge bit_clk)
    begin
        if (slot != 3'h6 && !stopped)
            slot = slot + 3'h1;
        else
        begin
            stopped = !run;
            slot = 3'h0;
            cur = word;
        end
        link_clk = stopped || slot < 3'h4;
        lanes = (stopped || lanes_idle) ? 3'h7 :
            {cur[14 + slot], cur[7 + slot], cur[slot]};
    end
endmodule : tlsprx_serializer_model
